// ### rtl/float_to_fixed.sv
// converts an ieee single value into two's complement fixed point
module float_to_fixed (
    input wire logic [31:0] flt,
    input wire logic [4:0] frac,
    input wire logic narrow,
    output logic [31:0] fixed
);
    logic [7:0] ex;
    logic signed [9:0] sh;
    logic [63:0] mant;
    logic [63:0] mag;
    logic [63:0] lim;
    always_comb begin
        ex = flt[30:23];
        mant = {40'h00_0000_0000, 1'b1, flt[22:0]};
        sh = $signed({2'b00, ex}) - 10'(tri_setup_pkg::FLT_BIAS + tri_setup_pkg::FLT_MANT_W)
            + $signed({5'b0_0000, frac});
        // out-of-range values saturate instead of wrapping
        lim = narrow ? 64'(32'h007F_FFFF) : 64'(32'h7FFF_FFFF);
        if (ex == 8'h00) begin
            mag = '0;
        end else if (sh > 10'sd31) begin
            mag = lim;
        end else if (sh >= 10'sd0) begin
            mag = mant << sh[4:0];
        end else if (sh < -10'sd24) begin
            mag = '0;
        end else begin
            mag = mant >> 6'(-sh);
        end
        if (mag > lim) begin
            mag = lim;
        end
        fixed = flt[31] ? 32'(-mag) : mag[31:0];
    end
endmodule // float_to_fixed

// ### rtl/tri_setup_device.sv
// triangle setup device: gradient registers, command decode, iterators
// What this block does
// - x step adds 1/w gradient, subtracts leftward
// - 1/w x gradient is signed 2.30
// - float gradients convert to internal fixed point
// - y step adds color gradients, subtracts negative
// - color gradients are bits 23:0, 12.12
// - y step adds depth gradient, subtracts negative
// - depth y gradient is signed 20.12
// - y step adds s/t gradients, subtracts negative
// - s/t y gradients are signed 14.18
// - host supplies texture deltas already divided
// - y step adds 1/w gradient, subtracts negative
// - 1/w y gradient is signed 2.30
// - command write starts one triangle render
// - host loads all registers before command
// - command bit 31 gives orientation
// - host sorts vertices by rising y
// - host computes area from vertex deltas
// - only command bit 31 is used
module tri_setup_device (
    input wire logic clock,
    input wire logic rstn,
    tri_setup_if.device link,
    input wire logic step_x,
    input wire logic step_x_rtl,
    input wire logic step_y,
    input wire logic step_y_neg,
    input wire logic iter_clear,
    input wire logic raster_done,
    output logic [31:0] iter [tri_setup_pkg::NUM_ITERS],
    output logic tri_start,
    output logic tri_cw,
    output logic busy
);
    // ==========================================================
    // address decode
    function automatic logic [3:0] grad_slot(input logic [7:0] a);
        case (a)
            tri_setup_pkg::TEX_S_STEP_X_FLOAT: grad_slot = 4'h0;
            tri_setup_pkg::TEX_T_STEP_X_FLOAT: grad_slot = 4'h1;
            tri_setup_pkg::RECIP_W_STEP_X_FIXED,
            tri_setup_pkg::RECIP_W_STEP_X_FLOAT: grad_slot = 4'h2;
            tri_setup_pkg::RED_STEP_Y_FIXED,
            tri_setup_pkg::RED_STEP_Y_FLOAT: grad_slot = 4'h3;
            tri_setup_pkg::GREEN_STEP_Y_FIXED,
            tri_setup_pkg::GREEN_STEP_Y_FLOAT: grad_slot = 4'h4;
            tri_setup_pkg::BLUE_STEP_Y_FIXED,
            tri_setup_pkg::BLUE_STEP_Y_FLOAT: grad_slot = 4'h5;
            tri_setup_pkg::ALPHA_STEP_Y_FIXED,
            tri_setup_pkg::ALPHA_STEP_Y_FLOAT: grad_slot = 4'h6;
            tri_setup_pkg::DEPTH_STEP_Y_FIXED,
            tri_setup_pkg::DEPTH_STEP_Y_FLOAT: grad_slot = 4'h7;
            tri_setup_pkg::TEX_S_STEP_Y_FIXED,
            tri_setup_pkg::TEX_S_STEP_Y_FLOAT: grad_slot = 4'h8;
            tri_setup_pkg::TEX_T_STEP_Y_FIXED,
            tri_setup_pkg::TEX_T_STEP_Y_FLOAT: grad_slot = 4'h9;
            tri_setup_pkg::RECIP_W_STEP_Y_FIXED,
            tri_setup_pkg::RECIP_W_STEP_Y_FLOAT: grad_slot = 4'hA;
            default: grad_slot = tri_setup_pkg::SLOT_NONE;
        endcase
    endfunction

    function automatic logic is_float(input logic [7:0] a);
        case (a)
            tri_setup_pkg::TEX_S_STEP_X_FLOAT,
            tri_setup_pkg::TEX_T_STEP_X_FLOAT,
            tri_setup_pkg::RECIP_W_STEP_X_FLOAT,
            tri_setup_pkg::RED_STEP_Y_FLOAT,
            tri_setup_pkg::GREEN_STEP_Y_FLOAT,
            tri_setup_pkg::BLUE_STEP_Y_FLOAT,
            tri_setup_pkg::ALPHA_STEP_Y_FLOAT,
            tri_setup_pkg::DEPTH_STEP_Y_FLOAT,
            tri_setup_pkg::TEX_S_STEP_Y_FLOAT,
            tri_setup_pkg::TEX_T_STEP_Y_FLOAT,
            tri_setup_pkg::RECIP_W_STEP_Y_FLOAT: is_float = 1'b1;
            default: is_float = 1'b0;
        endcase
    endfunction

    function automatic logic is_color(input logic [3:0] s);
        is_color = (s >= tri_setup_pkg::SLOT_R_Y) && (s <= tri_setup_pkg::SLOT_A_Y);
    endfunction

    function automatic logic [4:0] grad_frac(input logic [3:0] s);
        if (is_color(s)) begin
            grad_frac = tri_setup_pkg::COLOR_FRAC;
        end else if (s == tri_setup_pkg::SLOT_Z_Y) begin
            grad_frac = tri_setup_pkg::DEPTH_FRAC;
        end else if (s == tri_setup_pkg::SLOT_W_X || s == tri_setup_pkg::SLOT_W_Y) begin
            grad_frac = tri_setup_pkg::RECIP_W_FRAC;
        end else begin
            grad_frac = tri_setup_pkg::TEX_FRAC;
        end
    endfunction

    // one add or subtract step of an iterator
    function automatic logic [31:0] stepped(input logic [31:0] v, input logic [31:0] g,
                                            input logic en, input logic neg);
        if (!en) begin
            stepped = v;
        end else if (neg) begin
            stepped = v - g;
        end else begin
            stepped = v + g;
        end
    endfunction

    // ==========================================================
    // gradient load
    logic [3:0] slot;
    logic flt_write;
    logic cmd_hit;
    logic [31:0] conv_value;
    logic [31:0] fixed_value;
    logic [31:0] grad [tri_setup_pkg::NUM_GRADS];
    logic [31:0] active [tri_setup_pkg::NUM_GRADS];
    tri_setup_pkg::render_e state;

    assign slot = grad_slot(link.addr);
    assign flt_write = is_float(link.addr);
    assign cmd_hit = link.wr && (link.addr == tri_setup_pkg::DRAW_TRI_FIXED
                     || link.addr == tri_setup_pkg::DRAW_TRI_FLOAT);

    float_to_fixed conv (
        .flt(link.wdata),
        .frac(grad_frac(slot)),
        .narrow(is_color(slot)),
        .fixed(conv_value)
    );

    // color fixed form keeps bits 23:0 only, sign-extended to 32
    assign fixed_value = is_color(slot) ?
        {{(32 - tri_setup_pkg::COLOR_W){link.wdata[tri_setup_pkg::COLOR_W - 1]}},
         link.wdata[tri_setup_pkg::COLOR_W - 1:0]} : link.wdata;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < tri_setup_pkg::NUM_GRADS; i++) begin
                grad[i] <= tri_setup_pkg::GRAD_RESET;
            end
        end else if (link.wr && slot != tri_setup_pkg::SLOT_NONE) begin
            grad[slot] <= flt_write ? conv_value : fixed_value;
        end
    end

    // ==========================================================
    // triangle command
    // gradients are snapshotted so the host may load the next triangle early
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < tri_setup_pkg::NUM_GRADS; i++) begin
                active[i] <= tri_setup_pkg::GRAD_RESET;
            end
        end else if (cmd_hit) begin
            active <= grad;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tri_start <= 1'b0;
            tri_cw <= 1'b0;
        end else begin
            tri_start <= cmd_hit;
            if (cmd_hit) begin
                tri_cw <= link.wdata[tri_setup_pkg::SIGN_BIT];
            end
        end
    end

    // a new command while rendering restarts on the new triangle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= tri_setup_pkg::IDLE;
        end else begin
            case (state)
                tri_setup_pkg::IDLE: begin
                    if (cmd_hit) begin
                        state <= tri_setup_pkg::RENDER;
                    end
                end
                tri_setup_pkg::RENDER: begin
                    if (raster_done && !cmd_hit) begin
                        state <= tri_setup_pkg::IDLE;
                    end
                end
                default: state <= tri_setup_pkg::IDLE;
            endcase
        end
    end

    assign busy = (state == tri_setup_pkg::RENDER);

    // ==========================================================
    // parameter iterators
    // start values are outside this block; iter_clear zeroes them
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < tri_setup_pkg::NUM_ITERS; i++) begin
                iter[i] <= '0;
            end
        end else if (iter_clear) begin
            for (int i = 0; i < tri_setup_pkg::NUM_ITERS; i++) begin
                iter[i] <= '0;
            end
        end else if (busy) begin
            for (int i = 0; i < tri_setup_pkg::NUM_ITERS; i++) begin
                if (i >= tri_setup_pkg::ITER_S) begin
                    iter[i] <= stepped(stepped(iter[i], active[i + 3], step_y, step_y_neg),
                                       active[i - tri_setup_pkg::ITER_S],
                                       step_x, step_x_rtl);
                end else begin
                    iter[i] <= stepped(iter[i], active[i + 3], step_y, step_y_neg);
                end
            end
        end
    end
endmodule // tri_setup_device

// ### rtl/tri_setup_host.sv
// setup host: forwards register writes and computes the triangle area
module tri_setup_host (
    input wire logic clock,
    input wire logic rstn,
    tri_setup_if.host link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    // ==========================================================
    // vertex sort and area
    logic [31:0] vtx [3];
    logic [7:0] target;
    logic [10:0] loaded;
    logic err;
    logic [7:0] tri_count;
    logic signed [15:0] sx [3];
    logic signed [15:0] sy [3];
    logic signed [15:0] tx;
    logic signed [15:0] ty;
    logic signed [16:0] dx_ab;
    logic signed [16:0] dy_bc;
    logic signed [16:0] dx_bc;
    logic signed [16:0] dy_ab;
    logic signed [34:0] twice_area;
    logic [31:0] area;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            sx[i] = $signed(vtx[i][31:16]);
            sy[i] = $signed(vtx[i][15:0]);
        end
        // three compare-swaps give a <= b <= c in y
        for (int p = 0; p < 3; p++) begin
            tx = sx[p % 2];
            ty = sy[p % 2];
            if (sy[p % 2] > sy[p % 2 + 1]) begin
                sx[p % 2] = sx[p % 2 + 1];
                sy[p % 2] = sy[p % 2 + 1];
                sx[p % 2 + 1] = tx;
                sy[p % 2 + 1] = ty;
            end
        end
        dx_ab = 17'(sx[0]) - 17'(sx[1]);
        dy_bc = 17'(sy[1]) - 17'(sy[2]);
        dx_bc = 17'(sx[1]) - 17'(sx[2]);
        dy_ab = 17'(sy[0]) - 17'(sy[1]);
        twice_area = 35'(dx_ab * dy_bc) - 35'(dx_bc * dy_ab);
        area = {twice_area[34], 31'(twice_area >>> 1)};
    end

    // ==========================================================
    // command port and link writes
    logic data_wr;
    logic draw_wr;
    logic is_cmd;
    logic refuse;

    assign data_wr = wr && addr == tri_setup_pkg::HOST_DATA;
    assign draw_wr = wr && addr == tri_setup_pkg::HOST_DRAW;
    assign is_cmd = draw_wr || (data_wr && (target == tri_setup_pkg::DRAW_TRI_FIXED
                    || target == tri_setup_pkg::DRAW_TRI_FLOAT));
    // a command before every gradient was loaded is dropped
    assign refuse = is_cmd && loaded != tri_setup_pkg::ALL_LOADED;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            target <= 8'h00;
            for (int i = 0; i < 3; i++) begin
                vtx[i] <= '0;
            end
        end else if (wr) begin
            case (addr)
                tri_setup_pkg::HOST_TARGET: target <= wdata[7:0];
                tri_setup_pkg::HOST_VTX_A: vtx[0] <= wdata;
                tri_setup_pkg::HOST_VTX_B: vtx[1] <= wdata;
                tri_setup_pkg::HOST_VTX_C: vtx[2] <= wdata;
                default: ;
            endcase
        end
    end

    // texture deltas are forwarded as given, already divided by w
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            link.wr <= 1'b0;
            link.addr <= 8'h00;
            link.wdata <= '0;
        end else begin
            link.wr <= (data_wr || draw_wr) && !refuse;
            if ((data_wr || draw_wr) && !refuse) begin
                link.addr <= draw_wr ? tri_setup_pkg::DRAW_TRI_FIXED : target;
                link.wdata <= draw_wr ? area : wdata;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            loaded <= '0;
        end else if (data_wr && target < tri_setup_pkg::DRAW_TRI_FIXED) begin
            loaded <= loaded | 11'(1 << grad_index(target));
        end
    end

    function automatic logic [3:0] grad_index(input logic [7:0] a);
        if (a < tri_setup_pkg::RED_STEP_Y_FIXED) begin
            grad_index = (a < tri_setup_pkg::RECIP_W_STEP_X_FIXED) ? 4'(a[7:2]) : 4'h2;
        end else if (a < tri_setup_pkg::DEPTH_STEP_Y_FIXED) begin
            grad_index = 4'h3 + 4'(a[3:2]);
        end else if (a < tri_setup_pkg::TEX_S_STEP_Y_FIXED) begin
            grad_index = 4'h7;
        end else if (a < tri_setup_pkg::RECIP_W_STEP_Y_FIXED) begin
            grad_index = 4'h8 + 4'(a[2]);
        end else begin
            grad_index = 4'hA;
        end
    endfunction

    // set wins over a software clear in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            err <= 1'b0;
            tri_count <= 8'h00;
        end else begin
            if (refuse) begin
                err <= 1'b1;
            end else if (wr && addr == tri_setup_pkg::HOST_STATUS
                         && wdata[tri_setup_pkg::STATUS_ERR_BIT]) begin
                err <= 1'b0;
            end
            if (is_cmd && !refuse) begin
                tri_count <= tri_count + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                tri_setup_pkg::HOST_TARGET: rdata <= {24'h00_0000, target};
                tri_setup_pkg::HOST_VTX_A: rdata <= vtx[0];
                tri_setup_pkg::HOST_VTX_B: rdata <= vtx[1];
                tri_setup_pkg::HOST_VTX_C: rdata <= vtx[2];
                tri_setup_pkg::HOST_DRAW: rdata <= area;
                tri_setup_pkg::HOST_STATUS: rdata <= {tri_count, 7'h00, err, 5'h00, loaded};
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end
endmodule // tri_setup_host

// ### rtl/tri_setup_if.sv
// register write link between the setup host and the setup device
interface tri_setup_if;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    modport device (input wr, input addr, input wdata);
    modport host (output wr, output addr, output wdata);
endinterface

// ### rtl/tri_setup_pkg.sv
// shared register map, field layouts and constants for triangle gradient setup
package tri_setup_pkg;
    // ==========================================================
    // device register byte offsets
    localparam logic [7:0] TEX_S_STEP_X_FLOAT = 8'h00;
    localparam logic [7:0] TEX_T_STEP_X_FLOAT = 8'h04;
    localparam logic [7:0] RECIP_W_STEP_X_FIXED = 8'h08;
    localparam logic [7:0] RECIP_W_STEP_X_FLOAT = 8'h0C;
    localparam logic [7:0] RED_STEP_Y_FIXED = 8'h10;
    localparam logic [7:0] GREEN_STEP_Y_FIXED = 8'h14;
    localparam logic [7:0] BLUE_STEP_Y_FIXED = 8'h18;
    localparam logic [7:0] ALPHA_STEP_Y_FIXED = 8'h1C;
    localparam logic [7:0] RED_STEP_Y_FLOAT = 8'h20;
    localparam logic [7:0] GREEN_STEP_Y_FLOAT = 8'h24;
    localparam logic [7:0] BLUE_STEP_Y_FLOAT = 8'h28;
    localparam logic [7:0] ALPHA_STEP_Y_FLOAT = 8'h2C;
    localparam logic [7:0] DEPTH_STEP_Y_FIXED = 8'h30;
    localparam logic [7:0] DEPTH_STEP_Y_FLOAT = 8'h34;
    localparam logic [7:0] TEX_S_STEP_Y_FIXED = 8'h38;
    localparam logic [7:0] TEX_T_STEP_Y_FIXED = 8'h3C;
    localparam logic [7:0] TEX_S_STEP_Y_FLOAT = 8'h40;
    localparam logic [7:0] TEX_T_STEP_Y_FLOAT = 8'h44;
    localparam logic [7:0] RECIP_W_STEP_Y_FIXED = 8'h48;
    localparam logic [7:0] RECIP_W_STEP_Y_FLOAT = 8'h4C;
    localparam logic [7:0] DRAW_TRI_FIXED = 8'h50;
    localparam logic [7:0] DRAW_TRI_FLOAT = 8'h54;
    // ==========================================================
    // host command port byte offsets
    localparam logic [7:0] HOST_TARGET = 8'h00;
    localparam logic [7:0] HOST_DATA = 8'h04;
    localparam logic [7:0] HOST_VTX_A = 8'h08;
    localparam logic [7:0] HOST_VTX_B = 8'h0C;
    localparam logic [7:0] HOST_VTX_C = 8'h10;
    localparam logic [7:0] HOST_DRAW = 8'h14;
    localparam logic [7:0] HOST_STATUS = 8'h18;
    localparam int STATUS_ERR_BIT = 16;
    localparam int STATUS_CNT_LSB = 24;
    // ==========================================================
    // gradient slots, formats and number layouts
    localparam int NUM_GRADS = 11;
    localparam logic [3:0] SLOT_S_X = 4'h0;
    localparam logic [3:0] SLOT_T_X = 4'h1;
    localparam logic [3:0] SLOT_W_X = 4'h2;
    localparam logic [3:0] SLOT_R_Y = 4'h3;
    localparam logic [3:0] SLOT_A_Y = 4'h6;
    localparam logic [3:0] SLOT_Z_Y = 4'h7;
    localparam logic [3:0] SLOT_S_Y = 4'h8;
    localparam logic [3:0] SLOT_T_Y = 4'h9;
    localparam logic [3:0] SLOT_W_Y = 4'hA;
    localparam logic [3:0] SLOT_NONE = 4'hF;
    localparam logic [10:0] ALL_LOADED = 11'h7FF;
    localparam int NUM_ITERS = 8;
    localparam int ITER_S = 5;
    localparam int ITER_W = 7;
    localparam logic [4:0] COLOR_FRAC = 5'd12;
    localparam logic [4:0] DEPTH_FRAC = 5'd12;
    localparam logic [4:0] TEX_FRAC = 5'd18;
    localparam logic [4:0] RECIP_W_FRAC = 5'd30;
    localparam int COLOR_W = 24;
    localparam int SIGN_BIT = 31;
    localparam int FLT_MANT_W = 23;
    localparam int FLT_BIAS = 127;
    localparam logic [31:0] GRAD_RESET = 32'h0000_0000;
    typedef enum logic {IDLE, RENDER} render_e;
endpackage

// ### tb/tri_setup_asserts.sv
// concurrent checks on the setup link and the device command outputs
module tri_setup_asserts (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic tri_start,
    input wire logic tri_cw,
    input wire logic busy,
    input wire logic raster_done
);
    logic is_cmd;
    assign is_cmd = wr && (addr == tri_setup_pkg::DRAW_TRI_FIXED
        || addr == tri_setup_pkg::DRAW_TRI_FLOAT);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // command sequences
    sequence cmd_wr;
        is_cmd;
    endsequence
    sequence lone_cmd;
        cmd_wr ##1 !is_cmd;
    endsequence
    // ==========================================================
    // command start, orientation and busy
    cmd_start_a: assert property (cmd_wr |=> tri_start)
        else $error("command write gave no start pulse");
    start_cause_a: assert property (tri_start |-> $past(is_cmd))
        else $error("start pulse without a command write");
    start_pulse_a: assert property (lone_cmd |=> !tri_start)
        else $error("start pulse longer than one cycle");
    cw_sign_a: assert property (cmd_wr |=> tri_cw == $past(wdata[31]))
        else $error("orientation differs from command sign bit");
    cw_hold_a: assert property (!is_cmd |=> $stable(tri_cw))
        else $error("orientation changed without a command");
    start_busy_a: assert property (tri_start |-> busy)
        else $error("start pulse while not busy");
    busy_rise_a: assert property ($rose(busy) |-> tri_start)
        else $error("busy rose without a start");
    busy_hold_a: assert property (busy && !raster_done |=> busy)
        else $error("busy fell before raster done");
endmodule // tri_setup_asserts

// ### tb/triangle_gradient_setup_test.sv
// self-checking bench: host and device joined by the link, iterator model
module triangle_gradient_setup_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, iter_clear = 1'b0;
    logic step_x = 1'b0, step_x_rtl = 1'b0, step_y = 1'b0, step_y_neg = 1'b0;
    logic raster_done = 1'b0, tri_start, tri_cw, busy, mb;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rv;
    logic [31:0] iter [tri_setup_pkg::NUM_ITERS];
    logic [31:0] mi [8], gy_sn [8], gx_sn [8];
    logic [31:0] gy_st [8] = '{default: 32'h0000_0000};
    logic [31:0] gx_st [8] = '{default: 32'h0000_0000};
    int error_cnt = 0, num_checks = 0, ncmd = 0, nstart = 0, cyc = 0;
    always #10 clock = ~clock;
    tri_setup_if link ();
    tri_setup_host u_tri_setup_host (.clock(clock), .rstn(rstn), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    tri_setup_device u_tri_setup_device (.clock(clock), .rstn(rstn), .link(link),
        .step_x(step_x), .step_x_rtl(step_x_rtl), .step_y(step_y), .step_y_neg(step_y_neg),
        .iter_clear(iter_clear), .raster_done(raster_done), .iter(iter), .tri_start(tri_start),
        .tri_cw(tri_cw), .busy(busy));
    tri_setup_asserts u_tri_setup_asserts (.clock(clock), .rstn(rstn), .wr(link.wr),
        .addr(link.addr), .wdata(link.wdata), .tri_start(tri_start), .tri_cw(tri_cw),
        .busy(busy), .raster_done(raster_done));
    // ==========================================================
    // iterator model: snapshot taken when a command crosses the link
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mb <= 1'b0;
            mi <= '{default: 32'h0000_0000};
            gy_sn <= '{default: 32'h0000_0000};
            gx_sn <= '{default: 32'h0000_0000};
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (iter_clear) mi[i] <= 32'h0000_0000;
                else if (mb) mi[i] <= mi[i]
                    + (step_y ? (step_y_neg ? -gy_sn[i] : gy_sn[i]) : 32'h0000_0000)
                    + (step_x ? (step_x_rtl ? -gx_sn[i] : gx_sn[i]) : 32'h0000_0000);
            end
            if (u_tri_setup_asserts.is_cmd) begin
                mb <= 1'b1;
                gy_sn <= gy_st;
                gx_sn <= gx_st;
            end else if (raster_done) mb <= 1'b0;
        end
    end
    always @(negedge clock) begin
        nstart += (tri_start === 1'b1);
        if (rstn) for (int i = 0; i < 8; i++) cmp(iter[i], mi[i], "iterator");
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ==========================================================
    // tasks
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        cmp(rdata, e, "read data");
    endtask
    task grad(input logic [7:0] dev, input logic [31:0] d, input logic x, input int i,
        input logic [31:0] e);
        wr_reg(tri_setup_pkg::HOST_TARGET, {24'h00_0000, dev});
        wr_reg(tri_setup_pkg::HOST_DATA, d);
        if (x) gx_st[i] = e;
        else gy_st[i] = e;
    endtask
    task draw_chk(input logic [7:0] a, input logic [31:0] d, input logic cw);
        wr_reg(a, d);
        ncmd++;
        repeat (3) @(negedge clock);
        cmp({31'h0000_0000, tri_cw}, {31'h0000_0000, cw}, "orientation");
    endtask
    task steps(input int n);
        repeat (n) begin
            @(posedge clock);
            {step_x, step_x_rtl, step_y, step_y_neg} <= 4'($urandom);
            iter_clear <= ($urandom % 20) == 0;
        end
        @(posedge clock);
        {step_x, step_y, iter_clear} <= 3'h0;
    endtask
    task end_of_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(38));
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        rd_reg(8'h40, 32'h0000_0000);
        wr_reg(tri_setup_pkg::HOST_TARGET, {24'h00_0000, tri_setup_pkg::DRAW_TRI_FIXED});
        wr_reg(tri_setup_pkg::HOST_DATA, 32'h8000_0000);
        rd_reg(tri_setup_pkg::HOST_STATUS, 32'h0001_0000);
        wr_reg(tri_setup_pkg::HOST_STATUS, 32'h0001_0000);
        $display("test refusal done");
        for (int i = 0; i < 4; i++) begin
            rv = $urandom;
            grad(tri_setup_pkg::RED_STEP_Y_FIXED + 8'(4 * i), rv, 0, i, 32'(signed'(rv[23:0])));
        end
        rv = $urandom;
        grad(tri_setup_pkg::DEPTH_STEP_Y_FIXED, rv, 0, 4, rv);
        grad(tri_setup_pkg::TEX_S_STEP_Y_FIXED, -rv, 0, 5, -rv);
        grad(tri_setup_pkg::TEX_T_STEP_Y_FIXED, ~rv, 0, 6, ~rv);
        grad(tri_setup_pkg::RECIP_W_STEP_Y_FIXED, rv >> 1, 0, 7, rv >> 1);
        grad(tri_setup_pkg::RECIP_W_STEP_X_FIXED, 32'hC000_0001, 1, 7, 32'hC000_0001);
        grad(tri_setup_pkg::TEX_S_STEP_X_FLOAT, 32'h0000_0000, 1, 5, 32'h0000_0000);
        grad(tri_setup_pkg::TEX_T_STEP_X_FLOAT, 32'h3F00_0000, 1, 6, 32'h0002_0000);
        rd_reg(tri_setup_pkg::HOST_STATUS, 32'h0000_07FF);
        wr_reg(tri_setup_pkg::HOST_TARGET, {24'h00_0000, tri_setup_pkg::DRAW_TRI_FIXED});
        draw_chk(tri_setup_pkg::HOST_DATA, {1'b1, 31'($urandom)}, 1'b1);
        steps(60);
        $display("test fixed render done");
        // staged while rendering: the running triangle keeps its snapshot
        grad(tri_setup_pkg::RED_STEP_Y_FLOAT, 32'h3F80_0000, 0, 0, 32'h0000_1000);
        grad(tri_setup_pkg::GREEN_STEP_Y_FLOAT, 32'h3F80_0000, 0, 1, 32'h0000_1000);
        grad(tri_setup_pkg::GREEN_STEP_Y_FIXED, 32'h0000_0800, 0, 1, 32'h0000_0800);
        grad(tri_setup_pkg::DEPTH_STEP_Y_FLOAT, 32'hC000_0000, 0, 4, 32'hFFFF_E000);
        grad(tri_setup_pkg::TEX_S_STEP_Y_FLOAT, 32'h3F00_0000, 0, 5, 32'h0002_0000);
        grad(tri_setup_pkg::RECIP_W_STEP_Y_FLOAT, 32'h3E80_0000, 0, 7, 32'h1000_0000);
        grad(tri_setup_pkg::RECIP_W_STEP_X_FLOAT, 32'h3E80_0000, 1, 7, 32'h1000_0000);
        steps(40);
        wr_reg(tri_setup_pkg::HOST_TARGET, {24'h00_0000, tri_setup_pkg::DRAW_TRI_FLOAT});
        draw_chk(tri_setup_pkg::HOST_DATA, {1'b0, 31'($urandom)}, 1'b0);
        steps(60);
        @(posedge clock);
        raster_done <= 1'b1;
        @(posedge clock);
        raster_done <= 1'b0;
        @(negedge clock);
        cmp({31'h0000_0000, busy}, 32'h0000_0000, "busy");
        steps(30);
        $display("test float restart done");
        for (int m = 0; m < 2; m++) begin
            wr_reg(tri_setup_pkg::HOST_VTX_A, {(m ? 16'hFFFB : 16'h0005), 16'h0014});
            wr_reg(tri_setup_pkg::HOST_VTX_B, 32'h0000_0000);
            wr_reg(tri_setup_pkg::HOST_VTX_C, {(m ? 16'hFFF6 : 16'h000A), 16'h000A});
            draw_chk(tri_setup_pkg::HOST_DRAW, 32'h0000_0000, m[0]);
        end
        rd_reg(tri_setup_pkg::HOST_STATUS, {8'(ncmd), 13'h0000, 11'h7FF});
        cmp(32'(nstart), 32'(ncmd), "start count");
        $display("test area draw done");
        end_of_test();
    end
endmodule // triangle_gradient_setup_test
